// [rtl/bcd_pkg.sv]
// shared constants, types and register map of the decade counter block
package bcd_pkg;

  // ==========================================================
  // widths
  localparam int unsigned BCD_W       = 4;
  localparam int unsigned APB_ADDR_W  = 8;
  localparam int unsigned APB_DATA_W  = 32;

  // ==========================================================
  // counting range
  localparam logic [3:0]  BCD_FIRST   = 4'h0;
  localparam logic [3:0]  BCD_LAST    = 4'h9;
  localparam logic [3:0]  BCD_ONE     = 4'h1;

  // ==========================================================
  // register offsets
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_PULSE   = 8'h04;
  localparam logic [7:0]  OFS_STATUS  = 8'h08;

  // ==========================================================
  // control register fields
  localparam int unsigned CTRL_SW_EN  = 0;
  localparam int unsigned CTRL_SEL_LO = 1;
  localparam int unsigned CTRL_SEL_HI = 2;
  localparam int unsigned CTRL_CIN_N  = 3;
  localparam int unsigned CTRL_DATA   = 4;

  // ==========================================================
  // status register fields
  localparam int unsigned STAT_COUNT  = 0;
  localparam int unsigned STAT_COUT_N = 4;
  localparam int unsigned STAT_SEL    = 5;
  localparam int unsigned STAT_CIN_N  = 7;

  // ==========================================================
  // reset values
  localparam logic [3:0]  RST_COUNT   = 4'h0;
  localparam logic [1:0]  RST_SEL     = 2'h3;
  localparam logic        RST_CIN_N   = 1'b1;

  // mode code: bit 1 is the low select line, bit 0 the high one
  typedef enum logic [1:0] {
    MODE_LOAD = 2'b00,
    MODE_UP   = 2'b01,
    MODE_DOWN = 2'b10,
    MODE_HOLD = 2'b11
  } bcd_mode_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic [3:0]  count;
    logic        cp_prev;
    logic        sw_en;
    logic [1:0]  sw_sel;
    logic        sw_cin_n;
    logic [3:0]  sw_data;
    logic        sw_pulse;
  } bcd_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } bcd_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } bcd_apb_rsp_t;

endpackage

// [rtl/bcd_step.sv]
// next-count and carry-out logic of one decade stage
`timescale 1ns/1ps
module bcd_step
  import bcd_pkg::*;
(
  input  wire logic [3:0] count,
  input  wire bcd_mode_t  mode,
  input  wire logic       carry_in_n,
  input  wire logic [3:0] load_value,
  output logic [3:0]      next_count,
  output logic            carry_out_n
);

  // ==========================================================
  // next value
  always_comb
  begin
    next_count = count;
    case (mode)
      MODE_LOAD: next_count = load_value;
      MODE_UP:
      begin
        if (!carry_in_n)
        begin
          // codes above nine also fall back to zero
          if (count >= BCD_LAST)
            next_count = BCD_FIRST;
          else
            next_count = 4'(count + BCD_ONE);
        end
      end
      MODE_DOWN:
      begin
        if (!carry_in_n)
        begin
          if (count == BCD_FIRST)
            next_count = BCD_LAST;
          else
            next_count = 4'(count - BCD_ONE);
        end
      end
      MODE_HOLD: next_count = count;
      default:   next_count = count;
    endcase
  end

  // ==========================================================
  // terminal count, decoded straight from the stored bits
  always_comb
  begin
    carry_out_n = 1'b1;
    if (!carry_in_n && mode == MODE_UP && count == BCD_LAST)
      carry_out_n = 1'b0;
    if (!carry_in_n && mode == MODE_DOWN && count == BCD_FIRST)
      carry_out_n = 1'b0;
  end

endmodule // bcd_step

// [rtl/bcd_counter.sv]
// decade up/down counter with parallel load and an APB control port
//
// Behaviour
// - synchronous decade counter: up, down, load, hold
// - two selects plus carry-in choose mode
// - load value enters only on a counter clock edge, or on a software pulse while software has control
// - carry-out low at terminal count of direction while carry-in is low
// - carry-out decoded directly from stored count bits
// - count changes only on a counter clock rising edge, or on a software pulse while software has control
// - carry-in high freezes counting at edges
// - selects: 00 load, 01 up, 10 down, 11 hold
`timescale 1ns/1ps
module bcd_counter
  import bcd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        count_clock,
  input  wire logic        mode_select_lo,
  input  wire logic        mode_select_hi,
  input  wire logic        carry_in_n,
  input  wire logic [3:0]  load_value_in,
  output logic [3:0]       count_value_out,
  output logic             carry_out_n
);

  bcd_state_t   st_reg;
  bcd_state_t   st_next;
  bcd_apb_req_t req;
  bcd_apb_rsp_t rsp;
  bcd_mode_t    mode_eff;
  logic         cin_n_eff;
  logic [3:0]   data_eff;
  logic         count_edge;
  logic [3:0]   step_count;
  logic         step_cout_n;
  logic         setup_ph;
  logic         access_ph;
  logic         addr_ok;

  // ==========================================================
  // address decode, used by the error answer only; the read mux decodes paddr itself
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == OFS_CTRL) || (a == OFS_PULSE) || (a == OFS_STATUS);
  endfunction

  function automatic logic counts(input bcd_mode_t m);
    counts = (m == MODE_UP) || (m == MODE_DOWN);
  endfunction

  assign req.psel    = psel;
  assign req.penable = penable;
  assign req.pwrite  = pwrite;
  assign req.paddr   = paddr;
  assign req.pwdata  = pwdata;

  assign setup_ph  = req.psel && !req.penable;
  assign access_ph = req.psel && req.penable;
  assign addr_ok   = addr_known(req.paddr);

  // ==========================================================
  // control source: pins, or software when it takes over
  always_comb
  begin
    if (st_reg.sw_en)
    begin
      // register keeps the low select in bit 0, the mode code wants it in bit 1
      mode_eff   = bcd_mode_t'({st_reg.sw_sel[0], st_reg.sw_sel[1]});
      cin_n_eff  = st_reg.sw_cin_n;
      data_eff   = st_reg.sw_data;
      count_edge = st_reg.sw_pulse;
    end
    else
    begin
      mode_eff   = bcd_mode_t'({mode_select_lo, mode_select_hi});
      cin_n_eff  = carry_in_n;
      data_eff   = load_value_in;
      // counter clock is a sampled pin; a rising level is the edge
      count_edge = count_clock && !st_reg.cp_prev;
    end
  end

  // ==========================================================
  // counting stage
  bcd_step u_step (
    .count       (st_reg.count),
    .mode        (mode_eff),
    .carry_in_n  (cin_n_eff),
    .load_value  (data_eff),
    .next_count  (step_count),
    .carry_out_n (step_cout_n)
  );

  // ==========================================================
  // state update
  always_comb
  begin
    st_next          = st_reg;
    st_next.cp_prev  = count_clock;
    st_next.sw_pulse = 1'b0;

    // mode and carry-in together pick the new value
    if (count_edge)
      st_next.count = step_count;

    // read data is captured in the setup cycle so it leaves a flop
    if (setup_ph && !req.pwrite)
    begin
      st_next.prdata = '0;
      case (req.paddr)
        OFS_CTRL:
        begin
          st_next.prdata[CTRL_SW_EN]              = st_reg.sw_en;
          st_next.prdata[CTRL_SEL_HI:CTRL_SEL_LO] = st_reg.sw_sel;
          st_next.prdata[CTRL_CIN_N]              = st_reg.sw_cin_n;
          st_next.prdata[CTRL_DATA +: BCD_W]      = st_reg.sw_data;
        end
        OFS_STATUS:
        begin
          st_next.prdata[STAT_COUNT +: BCD_W] = st_reg.count;
          st_next.prdata[STAT_COUT_N]         = step_cout_n;
          st_next.prdata[STAT_SEL +: 2]       = mode_eff;
          st_next.prdata[STAT_CIN_N]          = cin_n_eff;
        end
        default: st_next.prdata = '0;
      endcase
    end

    // writes land at the access edge, the slave is never waited on
    if (access_ph && req.pwrite)
    begin
      case (req.paddr)
        OFS_CTRL:
        begin
          st_next.sw_en    = req.pwdata[CTRL_SW_EN];
          st_next.sw_sel   = req.pwdata[CTRL_SEL_HI:CTRL_SEL_LO];
          st_next.sw_cin_n = req.pwdata[CTRL_CIN_N];
          st_next.sw_data  = req.pwdata[CTRL_DATA +: BCD_W];
        end
        // only useful with software control; ignored otherwise
        OFS_PULSE: st_next.sw_pulse = st_reg.sw_en;
        default:   st_next.sw_pulse = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg          <= '0;
      st_reg.count    <= RST_COUNT;
      st_reg.sw_sel   <= RST_SEL;
      st_reg.sw_cin_n <= RST_CIN_N;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  assign rsp.prdata  = st_reg.prdata;
  assign rsp.pready  = 1'b1;
  assign rsp.pslverr = access_ph && !addr_ok;

  assign prdata          = rsp.prdata;
  assign pready          = rsp.pready;
  assign pslverr         = rsp.pslverr;
  assign count_value_out = st_reg.count;
  // combinational path: follows a load before the next edge
  assign carry_out_n     = step_cout_n;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_NO_EDGE_STABLE: assert property (
    !count_edge |=> count_value_out == $past(count_value_out)
  ) else $error("count moved without a counter clock edge");

  AST_HOLD_KEEPS: assert property (
    count_edge && mode_eff == MODE_HOLD |=> $stable(count_value_out)
  ) else $error("hold mode changed the count");

  AST_LOAD_TAKES: assert property (
    count_edge && mode_eff == MODE_LOAD |=> count_value_out == $past(data_eff)
  ) else $error("load edge did not store the load value");

  AST_LOAD_WAITS: assert property (
    mode_eff == MODE_LOAD && !count_edge && data_eff != count_value_out
    |=> count_value_out == $past(count_value_out)
  ) else $error("load value entered without an edge");

  AST_CIN_FREEZE: assert property (
    count_edge && counts(mode_eff) && cin_n_eff |=> $stable(count_value_out)
  ) else $error("counted while carry-in was high");

  AST_UP_STEP: assert property (
    count_edge && mode_eff == MODE_UP && !cin_n_eff && count_value_out < BCD_LAST
    |=> count_value_out == 4'($past(count_value_out) + BCD_ONE)
  ) else $error("up count did not add one");

  AST_DOWN_STEP: assert property (
    count_edge && mode_eff == MODE_DOWN && !cin_n_eff && count_value_out > BCD_FIRST
    && count_value_out <= BCD_LAST
    |=> count_value_out == 4'($past(count_value_out) - BCD_ONE)
  ) else $error("down count did not subtract one");

  AST_UP_WRAP: assert property (
    count_edge && mode_eff == MODE_UP && !cin_n_eff && count_value_out == BCD_LAST
    |=> count_value_out == BCD_FIRST
  ) else $error("up count did not wrap from nine to zero");

  AST_DOWN_WRAP: assert property (
    count_edge && mode_eff == MODE_DOWN && !cin_n_eff && count_value_out == BCD_FIRST
    |=> count_value_out == BCD_LAST
  ) else $error("down count did not wrap from zero to nine");

  AST_TC_LOW: assert property (
    !cin_n_eff && ((mode_eff == MODE_UP && count_value_out == BCD_LAST)
    || (mode_eff == MODE_DOWN && count_value_out == BCD_FIRST)) |-> !carry_out_n
  ) else $error("carry-out not low at terminal count");

  AST_TC_ONLY: assert property (
    !carry_out_n |-> counts(mode_eff) && !cin_n_eff
  ) else $error("carry-out low outside a counting mode");

  // a load of nine, three quiet cycles, then up: no new edge, yet carry-out falls
  AST_TC_AFTER_LOAD: assert property (
    count_edge && mode_eff == MODE_LOAD && data_eff == BCD_LAST
    ##1 (!count_edge && mode_eff == MODE_LOAD)[*3]
    ##1 (mode_eff == MODE_UP && !cin_n_eff) |-> !carry_out_n
  ) else $error("carry-out did not follow the loaded value");

  AST_SW_PULSE: assert property (
    access_ph && req.pwrite && req.paddr == OFS_PULSE && st_reg.sw_en
    |=> count_edge ##1 !st_reg.sw_pulse
  ) else $error("software pulse did not give exactly one counter edge");

  AST_EDGE_ONE_CYCLE: assert property (
    count_edge && !st_reg.sw_en |=> !count_edge
  ) else $error("one pin rise gave more than one counter edge");

  // loads may bring codes above nine, everything else must stay in range
  AST_RANGE_KEPT: assert property (
    count_value_out <= BCD_LAST && !(count_edge && mode_eff == MODE_LOAD)
    |=> count_value_out <= BCD_LAST
  ) else $error("counting left the decade range");

  AST_PINS_IGNORED: assert property (
    st_reg.sw_en && !st_reg.sw_pulse |=> $stable(count_value_out)
  ) else $error("count moved under software control without a pulse");

  // ==========================================================
  // bus and software control checks
  AST_CTRL_WRITE: assert property (
    access_ph && pwrite && paddr == OFS_CTRL
    |=> st_reg.sw_en == $past(pwdata[CTRL_SW_EN])
    && st_reg.sw_data == $past(pwdata[CTRL_DATA +: BCD_W])
  ) else $error("control write did not land");

  AST_PULSE_GATED: assert property (
    access_ph && pwrite && paddr == OFS_PULSE && !st_reg.sw_en |=> !st_reg.sw_pulse
  ) else $error("pulse write acted while pins had control");

  AST_STATUS_SNAP: assert property (
    setup_ph && !pwrite && paddr == OFS_STATUS
    |=> prdata[STAT_COUNT +: BCD_W] == $past(count_value_out)
    && prdata[STAT_COUT_N] == $past(carry_out_n)
  ) else $error("status read did not capture count and carry-out");

  AST_CTRL_READ: assert property (
    setup_ph && !pwrite && paddr == OFS_CTRL
    |=> prdata[CTRL_SW_EN] == $past(st_reg.sw_en)
    && prdata[CTRL_DATA +: BCD_W] == $past(st_reg.sw_data)
  ) else $error("control read did not return the stored fields");

  AST_READ_ZERO: assert property (
    setup_ph && !pwrite && (paddr == OFS_PULSE || paddr > OFS_STATUS)
    |=> prdata == '0
  ) else $error("read of a write-only or unmapped offset not zero");

  // read data must stand through the access phase, so it moves only on a read setup
  AST_PRDATA_HOLD: assert property (
    !(setup_ph && !pwrite) |=> $stable(prdata)
  ) else $error("read data changed outside a read setup");

  AST_MAPPED_NO_ERR: assert property (
    access_ph && (paddr == OFS_CTRL || paddr == OFS_STATUS) |-> !pslverr
  ) else $error("error answer on a mapped register");

  AST_UNMAPPED_ERR: assert property (
    access_ph && paddr > OFS_STATUS |-> pslverr
  ) else $error("no error answer on an unmapped offset");

  AST_UNMAPPED_KEEPS: assert property (
    access_ph && pwrite && paddr > OFS_STATUS
    |=> $stable(st_reg.sw_en) && $stable(st_reg.sw_sel) && $stable(st_reg.sw_data)
  ) else $error("unmapped write changed the control fields");

endmodule // bcd_counter

// [bench/bcd_far_logic.sv]
// model of the control logic that drives the counter pins
`timescale 1ns/1ps
module bcd_far_logic
  import bcd_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire bcd_mode_t  cmd_mode,
  input  wire logic       cmd_cin_n,
  input  wire logic [3:0] cmd_data,
  input  wire logic       cmd_step,
  output logic            count_clock,
  output logic            mode_select_lo,
  output logic            mode_select_hi,
  output logic            carry_in_n,
  output logic [3:0]      load_value_in
);
  // ==========================================================
  // pins
  // lines change on the same edge as the clock rise and are held through it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_clock    <= 1'b0;
      mode_select_lo <= 1'b1;
      mode_select_hi <= 1'b1;
      carry_in_n     <= 1'b1;
      load_value_in  <= 4'h0;
    end
    else
    begin
      mode_select_lo <= cmd_mode[1];
      mode_select_hi <= cmd_mode[0];
      carry_in_n     <= cmd_cin_n;
      load_value_in  <= cmd_data;
      // a rise is always followed by a low sample, so rises never merge
      count_clock    <= cmd_step & ~count_clock;
    end
  end
endmodule // bcd_far_logic

// [bench/bcd_counter_bench.sv]
// self-checking bench of the decade counter
`timescale 1ns/1ps
module bcd_counter_bench;
  import bcd_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, cclk, slo, shi, cin_n, cout_n, cmd_cin_n = 1'b1, cmd_step = 1'b0;
  logic [3:0] ldv, cnt, cmd_data = 4'h0;
  bcd_mode_t cmd_mode = MODE_HOLD;
  int err_count = 0, tests_run = 0, cyc = 0;

  always #20 pclk = ~pclk;

  bcd_far_logic far (.pclk(pclk), .presetn(presetn), .cmd_mode(cmd_mode),
    .cmd_cin_n(cmd_cin_n), .cmd_data(cmd_data), .cmd_step(cmd_step),
    .count_clock(cclk), .mode_select_lo(slo), .mode_select_hi(shi),
    .carry_in_n(cin_n), .load_value_in(ldv));

  bcd_counter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_clock(cclk), .mode_select_lo(slo), .mode_select_hi(shi),
    .carry_in_n(cin_n), .load_value_in(ldv), .count_value_out(cnt), .carry_out_n(cout_n));

  // ==========================================================
  // helpers
  task automatic final_report();
    $display("tests run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  // one APB transfer; waits for pready with no assumed latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // set the far-side lines, optionally give one counter clock, then settle
  task automatic pins(input bcd_mode_t m, input logic c, input logic [3:0] d, input logic st);
    @(posedge pclk);
    cmd_mode <= m;
    cmd_cin_n <= c;
    cmd_data <= d;
    cmd_step <= st;
    @(posedge pclk);
    cmd_step <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk({28'h0, cnt}, 32'h0);
    chk({31'h0, cout_n}, 32'h1);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0000000e);
    apb(1'b0, 8'h0c, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("test reset done");
  endtask

  task automatic t_load_up();
    pins(MODE_LOAD, 1'b1, 4'h7, 1'b0);
    chk({28'h0, cnt}, 32'h0);
    pins(MODE_LOAD, 1'b1, 4'h7, 1'b1);
    chk({28'h0, cnt}, 32'h7);
    pins(MODE_UP, 1'b0, 4'h0, 1'b1);
    chk({28'h0, cnt}, 32'h8);
    pins(MODE_UP, 1'b0, 4'h0, 1'b1);
    chk({27'h0, cout_n, cnt}, 32'h09);
    pins(MODE_UP, 1'b0, 4'h0, 1'b1);
    chk({27'h0, cout_n, cnt}, 32'h10);
    pins(MODE_LOAD, 1'b0, 4'h9, 1'b1);
    chk({27'h0, cout_n, cnt}, 32'h19);
    pins(MODE_UP, 1'b0, 4'h9, 1'b0);
    chk({27'h0, cout_n, cnt}, 32'h09);
    $display("test load and up done");
  endtask

  task automatic t_down_freeze();
    pins(MODE_LOAD, 1'b0, 4'h1, 1'b1);
    chk({27'h0, cout_n, cnt}, 32'h11);
    pins(MODE_DOWN, 1'b0, 4'h0, 1'b1);
    chk({27'h0, cout_n, cnt}, 32'h00);
    pins(MODE_DOWN, 1'b1, 4'h0, 1'b1);
    chk({27'h0, cout_n, cnt}, 32'h10);
    pins(MODE_DOWN, 1'b0, 4'h0, 1'b1);
    chk({27'h0, cout_n, cnt}, 32'h19);
    pins(MODE_HOLD, 1'b0, 4'h3, 1'b1);
    chk({27'h0, cout_n, cnt}, 32'h19);
    pins(MODE_UP, 1'b0, 4'h3, 1'b0);
    chk({27'h0, cout_n, cnt}, 32'h09);
    $display("test down and freeze done");
  endtask

  task automatic t_soft();
    apb(1'b1, OFS_PULSE, 32'h0);
    repeat (2) @(posedge pclk);
    #1;
    chk({28'h0, cnt}, 32'h9);
    apb(1'b1, OFS_CTRL, 32'h00000021);
    apb(1'b1, OFS_PULSE, 32'h0);
    repeat (2) @(posedge pclk);
    apb(1'b1, OFS_CTRL, 32'h00000005);
    pins(MODE_LOAD, 1'b0, 4'h6, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h00000032);
    apb(1'b1, OFS_PULSE, 32'h0);
    repeat (2) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({err, rd[30:0]}, 32'h00000033);
    apb(1'b1, 8'h10, 32'h0000000f);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h00000005);
    $display("test software control done");
  endtask

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    t_reset();
    t_load_up();
    t_down_freeze();
    t_soft();
    final_report();
  end
endmodule // bcd_counter_bench
